// [core/mgd_defs.svh]
// offsets, field positions, reset values and masks of the gap decoder
`ifndef MGD_DEFS_SVH
`define MGD_DEFS_SVH

// device register offsets on the configuration link
`define MGD_OFS_MID_CTL 8'h78
`define MGD_OFS_MID_UPPER 8'h7a
`define MGD_OFS_LOW_CTL 8'h7c
`define MGD_OFS_HIGH_START 8'h88
`define MGD_OFS_HIGH_END 8'h8c

// reset values
`define MGD_RST_MID_CTL 16'h0010
`define MGD_RST_MID_UPPER 16'h0000
`define MGD_RST_LOW_CTL 32'h0010_0000
`define MGD_RST_HIGH_START 32'h0000_0000
`define MGD_RST_HIGH_END 32'h0000_0000

// writable bits; everything else is reserved and reads zero
`define MGD_WMASK_MID_CTL 16'hfef0
`define MGD_WMASK_MID_UPPER 16'h0fff
`define MGD_WMASK_LOW_CTL 32'hfff0_0c1f
`define MGD_WMASK_HIGH_START 32'h8000_ffff
`define MGD_WMASK_HIGH_END 32'h0000_ffff

// field positions
`define MGD_MID_EN_BIT 15
`define MGD_MID_SIZE_HI 14
`define MGD_MID_SIZE_LO 10
`define MGD_MID_RECLAIM_BIT 9
`define MGD_MID_NIB_HI 7
`define MGD_MID_NIB_LO 4
`define MGD_LOW_START_HI 31
`define MGD_LOW_START_LO 20
`define MGD_LOW_EN_BIT 11
`define MGD_LOW_RECLAIM_BIT 10
`define MGD_LOW_SIZE_HI 4
`define MGD_LOW_SIZE_LO 0
`define MGD_HIGH_EN_BIT 31

// gap size codes
`define MGD_SZ_1MB 5'h00
`define MGD_SZ_2MB 5'h04
`define MGD_SZ_4MB 5'h0c
`define MGD_SZ_8MB 5'h1c
`define MGD_SZ_16MB 5'h1e
`define MGD_SZ_32MB 5'h1f

// controller APB register offsets
`define MGD_APB_CTRL 12'h000
`define MGD_APB_WDATA 12'h004
`define MGD_APB_RDATA 12'h008
`define MGD_APB_STATUS 12'h00c
`define MGD_APB_PROBE 12'h010

// controller field positions
`define MGD_CTRL_GO_BIT 0
`define MGD_CTRL_WR_BIT 1
`define MGD_CTRL_ADDR_HI 15
`define MGD_CTRL_ADDR_LO 8

`endif

// [core/mgd_pkg.sv]
// types shared by both ends of the gap decoder link
package mgd_pkg;
    // controller sequencer states, gray along idle-cfg-probe
    typedef enum logic [1:0]
    {
        MGD_IDLE = 2'b00,
        MGD_CFG = 2'b01,
        MGD_PROBE = 2'b11
    } mgd_state_t;
    // one-hot-ish gap hit vector: {high, middle, low}
    typedef logic [2:0] mgd_hit_t;
endpackage

// [core/mgd_if.sv]
// link between the gap decoder device and its controller
`timescale 1ns/1ps
interface mgd_if;
    // configuration access
    logic cfg_valid;
    logic cfg_write;
    logic [7:0] cfg_addr;
    logic [31:0] cfg_wdata;
    logic cfg_ack;
    logic cfg_err;
    logic [31:0] cfg_rdata;
    // memory address decode
    logic mem_valid;
    logic [15:0] mem_addr;
    logic mem_ack;
    logic mem_claim;
    logic mem_reclaim;
    logic [2:0] mem_gap;

    modport device
    (
        input cfg_valid, cfg_write, cfg_addr, cfg_wdata,
        output cfg_ack, cfg_err, cfg_rdata,
        input mem_valid, mem_addr,
        output mem_ack, mem_claim, mem_reclaim, mem_gap
    );
    modport host
    (
        output cfg_valid, cfg_write, cfg_addr, cfg_wdata,
        input cfg_ack, cfg_err, cfg_rdata,
        output mem_valid, mem_addr,
        input mem_ack, mem_claim, mem_reclaim, mem_gap
    );
endinterface

// [core/mgd_host_end.sv]
// controller end: APB registers that drive the gap decoder link
`timescale 1ns/1ps
`include "mgd_defs.svh"
module mgd_host_end
    import mgd_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // link to the device
    mgd_if.host link
);
    mgd_state_t state; // sequencer state
    logic cfg_write; // direction of the pending access
    logic [7:0] cfg_addr; // device offset of the pending access
    logic [31:0] wdata; // data for a device write
    logic [31:0] rdata; // last data read from the device
    logic err; // last device access hit an unmapped offset
    logic [15:0] probe_addr; // host address A[35:20] under test
    logic claim; // last probe was claimed
    logic reclaim; // last probe fell in a reclaiming gap
    logic [2:0] gap; // gaps hit by the last probe

    // APB decode
    wire apb_wr = psel & penable & pwrite;
    wire sel_ctrl = paddr == `MGD_APB_CTRL;
    wire sel_wdata = paddr == `MGD_APB_WDATA;
    wire sel_rdata = paddr == `MGD_APB_RDATA;
    wire sel_status = paddr == `MGD_APB_STATUS;
    wire sel_probe = paddr == `MGD_APB_PROBE;
    wire mapped = sel_ctrl | sel_wdata | sel_rdata | sel_status | sel_probe;
    wire busy = state != MGD_IDLE;
    // starts are ignored while busy so an access in flight stays intact
    wire start_cfg = apb_wr & sel_ctrl & pwdata[`MGD_CTRL_GO_BIT] & ~busy;
    wire start_probe = apb_wr & sel_probe & ~busy;
    wire [31:0] status_word = {25'h000_0000, gap, reclaim, claim, err, busy};

    // zero-wait slave; unmapped offsets answer with an error
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    // read selection, loaded into the read flop in the setup cycle
    wire [31:0] rd_mux = sel_ctrl ? {16'h0000, cfg_addr, 6'h00, cfg_write, 1'b0}
                       : sel_wdata ? wdata
                       : sel_rdata ? rdata
                       : sel_status ? status_word
                       : sel_probe ? {16'h0000, probe_addr}
                       : 32'h0000_0000;

    // read data from a flop; loading it on the setup edge keeps the
    // access phase free of wait states, at the cost of a status word
    // that is one cycle old when software sees it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel & ~penable)
            prdata <= rd_mux;
    end

    // link outputs follow the sequencer; held until the device acks
    assign link.cfg_valid = state == MGD_CFG;
    assign link.cfg_write = cfg_write;
    assign link.cfg_addr = cfg_addr;
    assign link.cfg_wdata = wdata;
    assign link.mem_valid = state == MGD_PROBE;
    assign link.mem_addr = probe_addr;

    // sequencer: one device access or one probe at a time
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= MGD_IDLE;
        else
        begin
            case (state)
                MGD_IDLE:
                begin
                    if (start_cfg)
                        state <= MGD_CFG;
                    else if (start_probe)
                        state <= MGD_PROBE;
                end
                MGD_CFG:
                begin
                    if (link.cfg_ack)
                        state <= MGD_IDLE;
                end
                MGD_PROBE:
                begin
                    if (link.mem_ack)
                        state <= MGD_IDLE;
                end
                default:
                    state <= MGD_IDLE;
            endcase
        end
    end

    // software-written fields
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_write <= 1'b0;
            cfg_addr <= 8'h00;
            wdata <= 32'h0000_0000;
            probe_addr <= 16'h0000;
        end
        else
        begin
            if (start_cfg)
            begin
                cfg_write <= pwdata[`MGD_CTRL_WR_BIT];
                cfg_addr <= pwdata[`MGD_CTRL_ADDR_HI:`MGD_CTRL_ADDR_LO];
            end
            if (apb_wr & sel_wdata & ~busy)
                wdata <= pwdata;
            if (start_probe)
                probe_addr <= pwdata[15:0];
        end
    end

    // results captured from the device answers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdata <= 32'h0000_0000;
            err <= 1'b0;
            claim <= 1'b0;
            reclaim <= 1'b0;
            gap <= 3'h0;
        end
        else
        begin
            if (state == MGD_CFG && link.cfg_ack)
            begin
                rdata <= link.cfg_rdata;
                err <= link.cfg_err;
            end
            if (state == MGD_PROBE && link.mem_ack)
            begin
                claim <= link.mem_claim;
                reclaim <= link.mem_reclaim;
                gap <= link.mem_gap;
            end
        end
    end
endmodule

// [core/mgd_device_end.sv]
// device end: memory gap registers and host address gap decode
`timescale 1ns/1ps
`include "mgd_defs.svh"

// Operation
// - middle gap enabled only by bit 15
// - middle size codes 2, 4, 16, 32 MB
// - middle and low reclaim bits, reset zero
// - middle start from nibble plus upper bits
// - software puts middle between low and high
// - low start bits 31:20, below 4 GB
// - low size codes 1..32 MB, enable bit 11
// - software puts low below the others
// - high gap enabled only by bit 31
// - high start from bits 15:0
// - high end bits 15:0, inclusive bound
module mgd_device_end
    import mgd_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // link from the controller
    mgd_if.device link
);
    // register storage
    logic [15:0] mid_ctl; // middle gap control
    logic [15:0] mid_upper; // middle gap upper start address
    logic [31:0] low_ctl; // low gap control
    logic [31:0] high_start; // high gap start and enable
    logic [31:0] high_end; // high gap last region
    // answer flops
    logic cfg_ack; // one-cycle answer to a configuration access
    logic cfg_err; // access hit no register
    logic [31:0] cfg_rdata; // read data of the answered access
    logic mem_ack; // one-cycle answer to a decode request
    logic mem_claim; // controller claims the access
    logic mem_reclaim; // access lies in a reclaiming gap
    mgd_hit_t mem_gap; // gaps that contain the access

    // converts a gap size code to megabytes; zero for reserved codes
    function automatic logic [5:0] size_mb(input logic [4:0] code,
                                           input logic allow_small);
        logic [5:0] mb;
        mb = 6'h00;
        case (code)
            `MGD_SZ_1MB: mb = allow_small ? 6'h01 : 6'h00;
            `MGD_SZ_2MB: mb = 6'h02;
            `MGD_SZ_4MB: mb = 6'h04;
            `MGD_SZ_8MB: mb = allow_small ? 6'h08 : 6'h00;
            `MGD_SZ_16MB: mb = 6'h10;
            `MGD_SZ_32MB: mb = 6'h20;
            default: mb = 6'h00;
        endcase
        return mb;
    endfunction

    // configuration access decode
    // a request is taken once; the ack cycle blocks a second take
    wire cfg_take = link.cfg_valid & ~cfg_ack;
    wire cfg_wr = cfg_take & link.cfg_write;
    wire sel_mid_ctl = link.cfg_addr == `MGD_OFS_MID_CTL;
    wire sel_mid_upper = link.cfg_addr == `MGD_OFS_MID_UPPER;
    wire sel_low_ctl = link.cfg_addr == `MGD_OFS_LOW_CTL;
    wire sel_high_start = link.cfg_addr == `MGD_OFS_HIGH_START;
    wire sel_high_end = link.cfg_addr == `MGD_OFS_HIGH_END;
    wire cfg_mapped = sel_mid_ctl | sel_mid_upper | sel_low_ctl
                    | sel_high_start | sel_high_end;

    // masked write values; reserved bits always land as zero
    // reserved bits ignored
    wire [15:0] wr_mid_ctl = link.cfg_wdata[15:0] & `MGD_WMASK_MID_CTL;
    wire [15:0] wr_mid_upper = link.cfg_wdata[15:0] & `MGD_WMASK_MID_UPPER;
    wire [31:0] wr_low_ctl = link.cfg_wdata & `MGD_WMASK_LOW_CTL;
    wire [31:0] wr_high_start = link.cfg_wdata & `MGD_WMASK_HIGH_START;
    wire [31:0] wr_high_end = link.cfg_wdata & `MGD_WMASK_HIGH_END;

    // read selection; 16-bit registers sit in the low half
    wire [31:0] rd_word = sel_mid_ctl ? {16'h0000, mid_ctl}
                        : sel_mid_upper ? {16'h0000, mid_upper}
                        : sel_low_ctl ? low_ctl
                        : sel_high_start ? high_start
                        : sel_high_end ? high_end
                        : 32'h0000_0000;

    // gap field extraction
    // middle enable bit
    wire mid_en = mid_ctl[`MGD_MID_EN_BIT];
    wire [5:0] mid_mb =
        size_mb(mid_ctl[`MGD_MID_SIZE_HI:`MGD_MID_SIZE_LO], 1'b0);
    wire [15:0] mid_base =
        {mid_upper[11:0], mid_ctl[`MGD_MID_NIB_HI:`MGD_MID_NIB_LO]};
    wire [15:0] low_base =
        {4'h0, low_ctl[`MGD_LOW_START_HI:`MGD_LOW_START_LO]};
    wire [5:0] low_mb =
        size_mb(low_ctl[`MGD_LOW_SIZE_HI:`MGD_LOW_SIZE_LO], 1'b1);
    wire low_en = low_ctl[`MGD_LOW_EN_BIT];
    wire mid_reclaim = mid_ctl[`MGD_MID_RECLAIM_BIT];
    wire low_reclaim = low_ctl[`MGD_LOW_RECLAIM_BIT];
    wire high_en = high_start[`MGD_HIGH_EN_BIT];
    wire [15:0] high_base = high_start[15:0];
    wire [15:0] high_last = high_end[15:0];

    // range compares in 1 MB units; 17 bits so the top cannot wrap
    wire [16:0] addr17 = {1'b0, link.mem_addr};
    wire [16:0] mid_top = {1'b0, mid_base} + {11'h000, mid_mb};
    wire [16:0] low_top = {1'b0, low_base} + {11'h000, low_mb};
    // a reserved size code gives a zero size, so that gap never hits
    wire mid_hit = mid_en & (addr17 >= {1'b0, mid_base}) & (addr17 < mid_top);
    // low gap never reaches 4 GB
    wire low_hit = low_en & (link.mem_addr[15:12] == 4'h0)
                 & (addr17 >= {1'b0, low_base}) & (addr17 < low_top);
    wire high_hit = high_en & (link.mem_addr >= high_base)
                  & (link.mem_addr <= high_last);
    // overlap is software's fault; hits are simply ORed
    wire any_hit = mid_hit | low_hit | high_hit;
    wire any_reclaim = (mid_hit & mid_reclaim) | (low_hit & low_reclaim);

    // register writes; a write lands on the take edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mid_ctl <= `MGD_RST_MID_CTL;
            mid_upper <= `MGD_RST_MID_UPPER;
            low_ctl <= `MGD_RST_LOW_CTL;
            high_start <= `MGD_RST_HIGH_START;
            high_end <= `MGD_RST_HIGH_END;
        end
        else if (cfg_wr)
        begin
            if (sel_mid_ctl)
                mid_ctl <= wr_mid_ctl;
            if (sel_mid_upper)
                mid_upper <= wr_mid_upper;
            if (sel_low_ctl)
                low_ctl <= wr_low_ctl;
            if (sel_high_start)
                high_start <= wr_high_start;
            if (sel_high_end)
                high_end <= wr_high_end;
        end
    end

    // configuration answer, one cycle after the take
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_ack <= 1'b0;
            cfg_err <= 1'b0;
            cfg_rdata <= 32'h0000_0000;
        end
        else
        begin
            cfg_ack <= cfg_take;
            if (cfg_take)
            begin
                cfg_err <= ~cfg_mapped;
                cfg_rdata <= link.cfg_write ? 32'h0000_0000 : rd_word;
            end
        end
    end

    // decode answer, one cycle after the request
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_ack <= 1'b0;
            mem_claim <= 1'b0;
            mem_reclaim <= 1'b0;
            mem_gap <= 3'h0;
        end
        else
        begin
            // back-to-back requests answered on alternate cycles
            mem_ack <= link.mem_valid & ~mem_ack;
            if (link.mem_valid & ~mem_ack)
            begin
                mem_claim <= ~any_hit;
                mem_reclaim <= any_reclaim;
                mem_gap <= {high_hit, mid_hit, low_hit};
            end
        end
    end

    // link outputs straight from the answer flops
    assign link.cfg_ack = cfg_ack;
    assign link.cfg_err = cfg_err;
    assign link.cfg_rdata = cfg_rdata;
    assign link.mem_ack = mem_ack;
    assign link.mem_claim = mem_claim;
    assign link.mem_reclaim = mem_reclaim;
    assign link.mem_gap = mem_gap;
endmodule

// [verification/mgd_link_monitor.sv]
// assertions on the link between the gap decoder device and its controller
`timescale 1ns/1ps
module mgd_link_monitor
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // configuration access
    input wire logic cfg_valid,
    input wire logic cfg_write,
    input wire logic [7:0] cfg_addr,
    input wire logic cfg_ack,
    input wire logic cfg_err,
    input wire logic [31:0] cfg_rdata,
    // address decode
    input wire logic mem_valid,
    input wire logic [15:0] mem_addr,
    input wire logic mem_ack,
    input wire logic mem_claim,
    input wire logic mem_reclaim,
    input wire logic [2:0] mem_gap
);
    // a take on the previous edge; each answer must match one take
    logic cfg_took;
    logic mem_took;
    // a read answer that was not refused
    wire rd_ok = cfg_ack && !cfg_write && !cfg_err;

    // remember takes, so a lost or a spurious answer both show up
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_took <= 1'b0;
            mem_took <= 1'b0;
        end
        else
        begin
            cfg_took <= cfg_valid && !cfg_ack;
            mem_took <= mem_valid && !mem_ack;
        end
    end

    default clocking mon_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    cfg_answer_a: assert property (cfg_ack == cfg_took)
        else $error("config answer not one cycle after take");
    mem_answer_a: assert property (mem_ack == mem_took)
        else $error("decode answer not one cycle after take");
    write_zero_a: assert property
        (cfg_ack && (cfg_write || cfg_err) |-> cfg_rdata == 32'h0000_0000)
        else $error("read data not zero on write or refusal");
    mid_resv_a: assert property
        (rd_ok && cfg_addr == 8'h78 |-> (cfg_rdata & 32'hffff_010f) == 0)
        else $error("middle control reserved bits not zero");
    upper_resv_a: assert property
        (rd_ok && cfg_addr == 8'h7a |-> (cfg_rdata & 32'hffff_f000) == 0)
        else $error("middle upper reserved bits not zero");
    low_resv_a: assert property
        (rd_ok && cfg_addr == 8'h7c |-> (cfg_rdata & 32'h000f_f3e0) == 0)
        else $error("low control reserved bits not zero");
    high_resv_a: assert property
        (rd_ok && cfg_addr == 8'h88 |-> (cfg_rdata & 32'h7fff_0000) == 0)
        else $error("high start reserved bits not zero");
    end_resv_a: assert property
        (rd_ok && cfg_addr == 8'h8c |-> (cfg_rdata & 32'hffff_0000) == 0)
        else $error("high end reserved bits not zero");
    claim_gap_a: assert property
        (mem_ack |-> mem_claim == (mem_gap == 3'b000))
        else $error("claim does not match gap hits");
    reclaim_hit_a: assert property
        (mem_ack && mem_reclaim |-> mem_gap[1:0] != 2'b00)
        else $error("reclaim without low or middle hit");
    below_4g_a: assert property
        (mem_ack && mem_addr[15:12] != 4'h0 |-> !mem_gap[0])
        else $error("low gap hit above 4 GB");
    result_hold_a: assert property
        (mem_ack |=> $stable(mem_gap) && $stable(mem_claim))
        else $error("decode result changed without a take");

    // main scenarios
    cover property (mem_ack && !mem_claim && mem_reclaim);
    cover property (mem_ack && mem_gap[2]);
    cover property (cfg_ack && cfg_err);
endmodule

// [verification/memory_gap_decode_regs_bench.sv]
// self-checking bench: APB controller and gap decoder joined by the link
`timescale 1ns/1ps
`include "mgd_defs.svh"
module memory_gap_decode_regs_bench;
    // APB side
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    // expected reads, oldest first
    logic [32:0] exp_q[$], msk_q[$], we, wm;
    int fail_count, compares, i, k;
    // scenario values
    logic [11:0] st;
    logic [15:0] base, he;
    logic [3:0] nib;
    logic rc;
    logic [4:0] code[6] = '{5'h00, 5'h04, 5'h0c, 5'h1c, 5'h1e, 5'h1f};
    logic [15:0] sz[6] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008,
        16'h0010, 16'h0020};
    logic [7:0] ofs[5] = '{8'h78, 8'h7a, 8'h7c, 8'h88, 8'h8c};
    // reset values of the five device registers
    logic [31:0] rst_val[5] = '{32'h0000_0010, 32'h0000_0000,
        32'h0010_0000, 32'h0000_0000, 32'h0000_0000};
    logic [31:0] wmsk[5] = '{32'h0000_fef0, 32'h0000_0fff, 32'hfff0_0c1f,
        32'h8000_ffff, 32'h0000_ffff};

    mgd_if mgd_if_inst();
    mgd_host_end mgd_host_end_inst(.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(mgd_if_inst));
    mgd_device_end mgd_device_end_inst(.pclk(pclk), .presetn(presetn),
        .link(mgd_if_inst));
    mgd_link_monitor mgd_link_monitor_inst(.pclk(pclk), .presetn(presetn),
        .cfg_valid(mgd_if_inst.cfg_valid), .cfg_write(mgd_if_inst.cfg_write),
        .cfg_addr(mgd_if_inst.cfg_addr), .cfg_ack(mgd_if_inst.cfg_ack),
        .cfg_err(mgd_if_inst.cfg_err), .cfg_rdata(mgd_if_inst.cfg_rdata),
        .mem_valid(mgd_if_inst.mem_valid), .mem_addr(mgd_if_inst.mem_addr),
        .mem_ack(mgd_if_inst.mem_ack), .mem_claim(mgd_if_inst.mem_claim),
        .mem_reclaim(mgd_if_inst.mem_reclaim), .mem_gap(mgd_if_inst.mem_gap));

    // 20 MHz clock
    always #25 pclk = ~pclk;

    // closing report, also reached when a wait runs out
    task automatic report_and_stop();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // compare one read answer, {pslverr, prdata}, under a mask
    task automatic check(input logic [32:0] e, m, got);
        compares++;
        if ((got & m) !== (e & m))
        begin
            fail_count++;
            $display("[ERR] read 0x%h expected %h seen %h", paddr, e, got);
        end
    endtask

    // watcher: every completed read with a pending note is compared
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1 && !pwrite
            && exp_q.size() > 0)
        begin
            we = exp_q.pop_front();
            wm = msk_q.pop_front();
            check(we, wm, {pslverr, prdata});
        end

    // one APB transfer; an idle cycle follows so psel is never re-driven
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        if (pready !== 1'b1)
        begin
            fail_count++;
            report_and_stop();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // poll the busy flag under a bound
    task automatic wait_idle();
        int n;
        for (n = 0; n < 20; n++)
        begin
            apb(1'b0, `MGD_APB_STATUS, 32'h0000_0000);
            if (rd[0] === 1'b0)
                break;
        end
        if (n == 20)
        begin
            fail_count++;
            report_and_stop();
        end
    endtask

    // note the expected answer, then read
    task automatic expect_rd(input logic [11:0] a, input logic [32:0] e, m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    // device register access through the controller
    task automatic dev_wr(input logic [7:0] o, input logic [31:0] d);
        apb(1'b1, `MGD_APB_WDATA, d);
        apb(1'b1, `MGD_APB_CTRL, {16'h0000, o, 8'h03});
        wait_idle();
    endtask
    task automatic dev_rd(input logic [7:0] o, input logic [31:0] e);
        apb(1'b1, `MGD_APB_CTRL, {16'h0000, o, 8'h01});
        wait_idle();
        expect_rd(`MGD_APB_RDATA, {1'b0, e}, {33{1'b1}});
    endtask

    // decode one address; claim is expected exactly when no gap hits
    task automatic probe(input logic [15:0] a, input logic [2:0] g,
        input logic r);
        apb(1'b1, `MGD_APB_PROBE, {16'h0000, a});
        wait_idle();
        expect_rd(`MGD_APB_STATUS, {26'h0, g, r, g == 3'b000, 2'b00},
            33'h1_0000_007d);
    endtask

    // main sequence
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        void'($urandom(32'h1bc3d57b));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values, then all gaps off
        for (k = 0; k < 5; k++)
            dev_rd(ofs[k], rst_val[k]);
        probe(16'h0001, 3'b000, 1'b0);
        // writable bits only, then clear
        for (k = 0; k < 5; k++)
        begin
            dev_wr(ofs[k], 32'hffff_ffff);
            dev_rd(ofs[k], wmsk[k]);
            dev_wr(ofs[k], 32'h0000_0000);
        end
        // refused device offset and unmapped APB word
        apb(1'b1, `MGD_APB_CTRL, 32'h0000_4001);
        wait_idle();
        expect_rd(`MGD_APB_STATUS, 33'h0_0000_0002,
            33'h1_0000_0003);
        expect_rd(12'h020, 33'h1_0000_0000, 33'h1_0000_0000);
        // low gap: every size code, edges inclusive and exclusive
        for (i = 0; i < 6; i++)
        begin
            st = 12'h100 + 12'($urandom_range(0, 255));
            rc = 1'($urandom_range(0, 1));
            base = {4'h0, st};
            dev_wr(8'h7c, {st, 8'h00, 1'b1, rc, 5'h00, code[i]});
            probe(base, 3'b001, rc);
            probe(base + sz[i] - 16'h0001, 3'b001, rc);
            probe(base + sz[i], 3'b000, 1'b0);
            probe(base - 16'h0001, 3'b000, 1'b0);
        end
        probe({4'h1, st}, 3'b000, 1'b0);
        // low gap at the top of 4 GB must stop at the boundary
        dev_wr(8'h7c, {12'hfff, 8'h00, 1'b1, 1'b0, 5'h00, 5'h1f});
        probe(16'h0fff, 3'b001, 1'b0);
        probe(16'h1000, 3'b000, 1'b0);
        dev_wr(8'h7c, {st, 8'h00, 1'b0, rc, 5'h00, 5'h00});
        probe(base, 3'b000, 1'b0);
        // middle gap above low, below high; 1 and 8 MB codes reserved
        for (i = 0; i < 6; i++)
        begin
            base = 16'h0200 + 16'($urandom_range(0, 1023));
            rc = 1'($urandom_range(0, 1));
            nib = base[3:0];
            dev_wr(8'h7a, {20'h0_0000, base[15:4]});
            dev_wr(8'h78, {16'h0000, 1'b1, code[i], rc, 1'b0, nib, 4'h0});
            k = (i == 0 || i == 3) ? 0 : 1;
            probe(base, k ? 3'b010 : 3'b000, k ? rc : 1'b0);
            probe(base + sz[i] - 16'h0001, k ? 3'b010 : 3'b000,
                k ? rc : 1'b0);
            probe(base + sz[i], 3'b000, 1'b0);
        end
        dev_wr(8'h78, {16'h0000, 1'b0, 5'h1f, 1'b1, 1'b0, nib, 4'h0});
        probe(base, 3'b000, 1'b0);
        // high gap with inclusive end
        for (i = 0; i < 3; i++)
        begin
            base = 16'h8000 + 16'($urandom_range(0, 28671));
            he = base + 16'($urandom_range(0, 7));
            dev_wr(8'h88, {1'b1, 15'h0000, base});
            dev_wr(8'h8c, {16'h0000, he});
            probe(base, 3'b100, 1'b0);
            probe(he, 3'b100, 1'b0);
            probe(he + 16'h0001, 3'b000, 1'b0);
            probe(base - 16'h0001, 3'b000, 1'b0);
        end
        dev_wr(8'h88, {1'b0, 15'h0000, base});
        probe(base, 3'b000, 1'b0);
        report_and_stop();
    end
endmodule
